// ==== fpc_pkg.sv ====
package fpc_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] FPC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] FPC_ADDR_TARGET = 8'h04;
   localparam logic [7:0] FPC_ADDR_UNLOCK = 8'h08;
   localparam logic [7:0] FPC_ADDR_PROT = 8'h0C;
   localparam logic [7:0] FPC_ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] FPC_ADDR_IRQ_CLR = 8'h14;
   localparam logic [7:0] FPC_ADDR_IRQ_EN = 8'h18;

   // ==========================================================
   // programming_control fields
   localparam int FPC_BIT_TRIGGER = 15;
   localparam int FPC_BIT_ENABLE = 14;
   localparam int FPC_BIT_FAIL = 13;
   localparam int FPC_BIT_UVERR = 12;
   localparam int FPC_BIT_UVACT = 11;
   localparam logic [31:0] FPC_CTRL_RESET = 32'h0000_0000;

   // unlock keys, values arbitrary
   localparam logic [31:0] FPC_KEY_FIRST = 32'h5A5A_0F0F;
   localparam logic [31:0] FPC_KEY_SECOND = 32'hA5A5_F0F0;

   // interrupt status bits
   localparam int FPC_IRQ_DONE = 0;
   localparam int FPC_IRQ_FAIL = 1;
   localparam int FPC_IRQ_UV = 2;

   // ==========================================================
   // operation codes
   localparam logic [3:0] FPC_OP_NOP0 = 4'h0;
   localparam logic [3:0] FPC_OP_WORD = 4'h1;
   localparam logic [3:0] FPC_OP_NOP2 = 4'h2;
   localparam logic [3:0] FPC_OP_ROW = 4'h3;
   localparam logic [3:0] FPC_OP_PAGE = 4'h4;
   localparam logic [3:0] FPC_OP_ERASE_ALL = 4'h5;
   localparam logic [3:0] FPC_OP_NOP6 = 4'h6;

   typedef enum logic [2:0] {
      FPC_IDLE = 3'b001,
      FPC_BUSY = 3'b010,
      FPC_FINISH = 3'b100
   } fpc_state_t;

   // command toward the flash array
   typedef struct packed {
      logic start;
      logic [3:0] op;
      logic [31:0] addr;
   } fpc_flash_cmd_t;

   typedef struct packed {
      fpc_state_t fsm;
      logic trig;
      logic en;
      logic fail;
      logic uverr;
      logic [3:0] op;
      logic [31:0] tgt;
      logic [31:0] plim;
      logic key1;
      logic unl;
      logic [2:0] ist;
      logic [2:0] ien;
      logic [31:0] rdata;
      logic slverr;
      fpc_flash_cmd_t cmd;
   } fpc_regs_t;

endpackage

// ==== fpc.sv ====
`timescale 1ns/1ps

// Overview of operation
// - setting the trigger bit starts the chosen operation and hardware clears it when the operation ends.
// - the trigger bit can be set only while program enable is one and the unlock sequence has just been done.
// - reset clears program enable and every other control bit: trigger, fail, both error flags and operation select.
// - program enable one allows trigger writes and turns the low-voltage detector on, zero disables both.
// - the fail flag is set when a program or erase does not complete and stays zero on success.
// - with the detector on, a low-voltage detection sets the undervoltage error flag.
// - the undervoltage active bit follows the current low-voltage event while the detector is on.
// - the operation select field can change only while program enable is zero.
// - code 0101 erases the whole array, only if no page is protected.
// - code 0100 erases the page at the target location unless it is protected.
// - code 0011 programs the row at the target location unless it is protected.
// - code 0001 programs the word at the target location unless it is protected.
// - codes 0000, 0010 and 0110 do nothing and codes 0111 to 1111 are reserved and invalid.
// - triggering with code 0000 clears the fail and undervoltage error flags.
module fpc_top
   import fpc_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output fpc_flash_cmd_t flash_cmd,
   input wire logic flash_done,
   input wire logic flash_error,
   input wire logic lv_detect,
   output logic lvd_enable,
   output logic irq
);

   // ==========================================================
   // helpers
   function automatic logic is_flash_op(input logic [3:0] op);
      is_flash_op = (op == FPC_OP_WORD) || (op == FPC_OP_ROW) ||
                    (op == FPC_OP_PAGE) || (op == FPC_OP_ERASE_ALL);
   endfunction

   function automatic logic is_nop(input logic [3:0] op);
      is_nop = (op == FPC_OP_NOP0) || (op == FPC_OP_NOP2) ||
               (op == FPC_OP_NOP6);
   endfunction

   // locations below the limit are protected
   function automatic logic is_protected(input logic [3:0] op,
                                         input logic [31:0] addr,
                                         input logic [31:0] lim);
      if (op == FPC_OP_ERASE_ALL) begin
         is_protected = (lim != 32'h0000_0000);
      end else begin
         is_protected = (addr < lim);
      end
   endfunction

   fpc_regs_t q;
   fpc_regs_t d;
   logic wr;
   logic setup;
   logic uv_active;
   logic trig_set;
   logic [2:0] ev;

   // ==========================================================
   // bus and status decode
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign pready = psel && penable;
   assign prdata = q.rdata;
   assign pslverr = q.slverr && pready;
   assign flash_cmd = q.cmd;
   assign lvd_enable = q.en;
   assign uv_active = q.en && lv_detect;
   assign irq = |(q.ist & q.ien);
   // a set request needs enable and a fresh unlock, both as held before
   assign trig_set = wr && (paddr == FPC_ADDR_CTRL) &&
                     pwdata[FPC_BIT_TRIGGER] && q.en && q.unl &&
                     (q.fsm == FPC_IDLE);

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      ev = 3'b000;
      d.cmd.start = 1'b0;
      // read data is captured in setup so it leaves a flop
      if (setup) begin
         d.slverr = 1'b0;
         d.rdata = 32'h0000_0000;
         case (paddr)
            FPC_ADDR_CTRL: begin
               d.rdata[FPC_BIT_TRIGGER] = q.trig;
               d.rdata[FPC_BIT_ENABLE] = q.en;
               d.rdata[FPC_BIT_FAIL] = q.fail;
               d.rdata[FPC_BIT_UVERR] = q.uverr;
               d.rdata[FPC_BIT_UVACT] = uv_active;
               d.rdata[3:0] = q.op;
            end
            FPC_ADDR_TARGET: d.rdata = q.tgt;
            FPC_ADDR_PROT: d.rdata = q.plim;
            FPC_ADDR_IRQ_STAT: d.rdata[2:0] = q.ist;
            FPC_ADDR_IRQ_EN: d.rdata[2:0] = q.ien;
            FPC_ADDR_UNLOCK, FPC_ADDR_IRQ_CLR: d.rdata = 32'h0000_0000;
            default: d.slverr = 1'b1;
         endcase
      end
      // register writes
      if (wr) begin
         case (paddr)
            FPC_ADDR_CTRL: begin
               d.en = pwdata[FPC_BIT_ENABLE];
               if (!q.en) begin
                  d.op = pwdata[3:0];
               end
               // any control write spends the unlock
               d.unl = 1'b0;
            end
            FPC_ADDR_TARGET: begin
               if (!q.trig) begin
                  d.tgt = pwdata;
               end
            end
            FPC_ADDR_UNLOCK: begin
               d.unl = q.key1 && (pwdata == FPC_KEY_SECOND);
            end
            FPC_ADDR_PROT: begin
               if (!q.trig) begin
                  d.plim = pwdata;
               end
            end
            FPC_ADDR_IRQ_CLR: d.ist = q.ist & ~pwdata[2:0];
            FPC_ADDR_IRQ_EN: d.ien = pwdata[2:0];
            default: d.unl = q.unl;
         endcase
      end
      // the unlock pair must be two back-to-back writes to the key
      if (wr) begin
         d.key1 = (paddr == FPC_ADDR_UNLOCK) &&
                  (pwdata == FPC_KEY_FIRST);
      end
      // sequencer
      case (q.fsm)
         FPC_IDLE: begin
            if (trig_set) begin
               d.trig = 1'b1;
               if (is_flash_op(q.op) &&
                   !is_protected(q.op, q.tgt, q.plim)) begin
                  d.cmd.start = 1'b1;
                  d.cmd.op = q.op;
                  d.cmd.addr = q.tgt;
                  d.fsm = FPC_BUSY;
               end else begin
                  d.fsm = FPC_FINISH;
               end
            end
         end
         FPC_BUSY: begin
            if (flash_done) begin
               d.fail = flash_error || uv_active;
               d.trig = 1'b0;
               d.fsm = FPC_IDLE;
               ev[FPC_IRQ_DONE] = 1'b1;
               ev[FPC_IRQ_FAIL] = flash_error || uv_active;
            end
         end
         FPC_FINISH: begin
            // nop codes finish at once, reserved or protected fail
            if (q.op == FPC_OP_NOP0) begin
               d.fail = 1'b0;
               d.uverr = 1'b0;
            end else if (!is_nop(q.op)) begin
               d.fail = 1'b1;
               ev[FPC_IRQ_FAIL] = 1'b1;
            end
            d.trig = 1'b0;
            d.fsm = FPC_IDLE;
            ev[FPC_IRQ_DONE] = 1'b1;
         end
         default: begin
            d.fsm = FPC_IDLE;
            d.trig = 1'b0;
         end
      endcase
      // detection wins over the clear done in the same cycle
      if (uv_active) begin
         d.uverr = 1'b1;
         ev[FPC_IRQ_UV] = 1'b1;
      end
      // events win over a software clear of the same bit
      d.ist = d.ist | ev;
   end

   // ==========================================================
   // state register; every field resets to zero except fsm, which loads FPC_IDLE
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.fsm <= FPC_IDLE;
         q.en <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_nop_finish;
      (q.fsm == FPC_FINISH) && (q.op == FPC_OP_NOP0);
   endsequence

   sequence s_flash_end;
      (q.fsm == FPC_BUSY) && flash_done && flash_error;
   endsequence

   AST_TRIG_CLEARS: assert property (
      (q.fsm == FPC_FINISH) |=> !q.trig && (q.fsm == FPC_IDLE))
      else $error("trigger not cleared after finish");

   AST_START_ON_TRIG: assert property (
      $rose(q.trig) && (q.fsm == FPC_BUSY) |-> flash_cmd.start
      ##1 !flash_cmd.start)
      else $error("flash start not a single pulse with trigger");

   AST_TRIG_GATED: assert property (
      $rose(q.trig) |-> $past(q.en) && $past(q.unl))
      else $error("trigger set without enable and unlock");

   AST_LVD_OFF: assert property (
      !q.en |-> !lvd_enable && !uv_active)
      else $error("detector active while enable is low");

   AST_FAIL_ON_ERROR: assert property (
      s_flash_end |=> q.fail && !q.trig && q.ist[FPC_IRQ_FAIL])
      else $error("flash error did not set fail flag");

   AST_UVERR_SET: assert property (
      q.en && lv_detect |=> q.uverr && q.ist[FPC_IRQ_UV])
      else $error("low voltage did not set error flag");

   AST_OP_LOCKED: assert property (
      $past(q.en) |-> q.op == $past(q.op))
      else $error("operation select changed while enabled");

   AST_MASS_PROTECT: assert property (
      flash_cmd.start && (flash_cmd.op == FPC_OP_ERASE_ALL)
      |-> q.plim == 32'h0000_0000)
      else $error("whole-array erase issued with protection set");

   AST_NO_PROTECTED: assert property (
      flash_cmd.start |->
      !is_protected(flash_cmd.op, flash_cmd.addr, q.plim))
      else $error("operation issued to a protected location");

   AST_NOP_NO_START: assert property (
      $rose(q.trig) && !is_flash_op(q.op) |->
      !flash_cmd.start ##1 !q.trig)
      else $error("invalid code reached the flash array");

   AST_CLEAR_FLAGS: assert property (
      s_nop_finish |=> !q.fail)
      else $error("nop trigger did not clear fail flag");

   // trigger with code 0000 clears the stale detector error too
   AST_UVERR_CLEARS: assert property (
      (q.fsm == FPC_FINISH) && (q.op == FPC_OP_NOP0) && !uv_active
      |=> !q.uverr)
      else $error("nop trigger did not clear undervoltage error");

   // ==========================================================
   // command, flag and reset checks
   // an accepted trigger: the code held in the field, target open
   sequence s_issue(logic [3:0] code);
      $rose(q.trig) && (q.op == code) &&
      !is_protected(q.op, q.tgt, q.plim);
   endsequence

   // one command pulse that carries the code and the held target
   sequence s_cmd_pulse(logic [3:0] code);
      flash_cmd.start && (flash_cmd.op == code) &&
      (flash_cmd.addr == q.tgt) ##1 !flash_cmd.start;
   endsequence

   // the whole array goes whenever no limit is set
   AST_ERASE_ALL_CMD: assert property (
      s_issue(FPC_OP_ERASE_ALL) |-> s_cmd_pulse(FPC_OP_ERASE_ALL))
      else $error("whole-array erase not sent to the array");

   // page erase at the held target
   AST_PAGE_CMD: assert property (
      s_issue(FPC_OP_PAGE) |-> s_cmd_pulse(FPC_OP_PAGE))
      else $error("page erase not sent to the array");

   // row program at the held target
   AST_ROW_CMD: assert property (
      s_issue(FPC_OP_ROW) |-> s_cmd_pulse(FPC_OP_ROW))
      else $error("row program not sent to the array");

   // word program at the held target
   AST_WORD_CMD: assert property (
      s_issue(FPC_OP_WORD) |-> s_cmd_pulse(FPC_OP_WORD))
      else $error("word program not sent to the array");

   // the bit stays up for as long as the array works
   AST_TRIG_HELD: assert property (
      (q.fsm == FPC_BUSY) && !flash_done |=> q.trig)
      else $error("trigger cleared before the array finished");

   // a clean answer with good supply leaves no failure behind
   AST_OK_CLEAN: assert property (
      (q.fsm == FPC_BUSY) && flash_done && !flash_error && !uv_active
      |=> !q.fail)
      else $error("fail flag set after a clean completion");

   // reserved codes never pass as a success
   AST_RESERVED_FAIL: assert property (
      (q.fsm == FPC_FINISH) && !is_flash_op(q.op) && !is_nop(q.op)
      |=> q.fail)
      else $error("reserved code did not set the fail flag");

   // with enable low a trigger write must be dropped
   AST_TRIG_NEEDS_EN: assert property (
      !q.en |=> !$rose(q.trig))
      else $error("trigger set while program enable was low");

   // status read shows the detector as it stood in the setup cycle
   AST_UVACT_READ: assert property (
      setup && (paddr == FPC_ADDR_CTRL) |=>
      prdata[FPC_BIT_UVACT] == $past(q.en && lv_detect))
      else $error("undervoltage active bit does not follow detector");

   // first cycle out of reset: enable, detector and trigger all low
   AST_RESET_CLEARS: assert property (
      $rose(rstn) |-> !q.en && !lvd_enable && !q.trig)
      else $error("program enable not cleared by reset");

endmodule

// ==== fpc_flash_model.sv ====
`timescale 1ns/1ps

// =====================================================
// flash array stand-in: answers a command after 1 or 13 cycles
module fpc_flash_model
   import fpc_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input fpc_flash_cmd_t cmd,
   input wire logic slow,
   input wire logic err_req,
   output logic done,
   output logic error
);
   logic busy_q;
   logic [3:0] cnt_q;

   // error toggles outside done so a late sample never looks valid
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'h0;
         cnt_q <= 4'h0;
         done <= 1'h0;
         error <= 1'h0;
      end else begin
         done <= 1'h0;
         error <= ~error;
         if (cmd.start) begin
            busy_q <= 1'h1;
            cnt_q <= slow ? 4'hC : 4'h0;
         end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'h0;
            done <= 1'h1;
            error <= err_req;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps

module tb;
   import fpc_pkg::*;
   localparam logic [31:0] TGT = 32'h0000_0100;
   logic clock, rstn, psel, penable, pwrite, lv_detect, slow, err_req;
   logic pready, pslverr, lvd_enable, irq, done, error, sl;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, last_addr;
   logic [3:0] last_op;
   fpc_flash_cmd_t cmd;
   int errors, n_compared, starts;

   fpc_top dut_u (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .flash_cmd(cmd), .flash_done(done),
      .flash_error(error), .lv_detect, .lvd_enable, .irq);
   fpc_flash_model fm_u (.clock, .rstn, .cmd, .slow, .err_req, .done,
      .error);

   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end

   // remember what each command to the array carried
   always @(posedge clock) begin
      if (cmd.start === 1'h1) begin
         starts++;
         last_op = cmd.op;
         last_addr = cmd.addr;
      end
   end

   // =====================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask

   // one apb transfer; the slave is trusted for no wait count
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      // wait as long as the slave asks; the watchdog ends a hang
      do begin
         @(posedge clock);
      end while (pready !== 1'h1);
      rd = prdata;
      sl = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic unlock();
      wr(FPC_ADDR_UNLOCK, FPC_KEY_FIRST);
      wr(FPC_ADDR_UNLOCK, FPC_KEY_SECOND);
   endtask

   // full sequence: select, enable, unlock, trigger, wait for clear
   task automatic run(input logic [3:0] op, input logic e, input logic ns,
                      input logic ef);
      int s0, k;
      wr(FPC_ADDR_CTRL, 32'h0);
      wr(FPC_ADDR_CTRL, {28'h0, op});
      wr(FPC_ADDR_CTRL, 32'h0000_4000 | {28'h0, op});
      err_req <= e;
      unlock();
      s0 = starts;
      wr(FPC_ADDR_CTRL, 32'h0000_C000 | {28'h0, op});
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      if (slow && ns) chk({31'h0, rd[15]}, 32'h1);
      k = 0;
      while (rd[15] !== 1'h0 && k < 40) begin
         apb(1'h0, FPC_ADDR_CTRL, 32'h0);
         k++;
      end
      chk(32'(starts - s0), {31'h0, ns});
      if (ns) chk({last_op, last_addr[27:0]}, {op, TGT[27:0]});
      chk({16'h0, rd[15:0]}, {18'h1, ef, 9'h0, op});
      slow <= ~slow;
   endtask

   // =====================================================
   // scenarios
   task automatic t_reset();
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk(rd, FPC_CTRL_RESET);
      apb(1'h0, 8'h40, 32'h0);
      chk({sl, rd[30:0]}, 32'h8000_0000);
      wr(FPC_ADDR_CTRL, 32'h0000_4000);
      // enable flop moves at the write edge, so look one edge later
      @(posedge clock);
      chk({31'h0, lvd_enable}, 32'h1);
      rstn <= 1'h0;
      @(posedge clock);
      rstn <= 1'h1;
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk({rd[14], 30'h0, lvd_enable}, 32'h0);
      $display("end of reset test");
   endtask

   task automatic t_guard();
      wr(FPC_ADDR_TARGET, TGT);
      wr(FPC_ADDR_CTRL, 32'h1);
      wr(FPC_ADDR_CTRL, 32'h0000_4001);
      wr(FPC_ADDR_CTRL, 32'h0000_4003);
      wr(FPC_ADDR_CTRL, 32'h0000_C003);
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_4001);
      wr(FPC_ADDR_CTRL, 32'h0);
      unlock();
      wr(FPC_ADDR_CTRL, 32'h0000_C001);
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk({rd[27:0], 4'(starts)}, {28'h000_4001, 4'h0});
      $display("end of guard test");
   endtask

   task automatic t_lv();
      wr(FPC_ADDR_IRQ_EN, 32'h4);
      lv_detect <= 1'h1;
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk({rd[30:0], irq}, {31'h0000_5801, 1'h1});
      lv_detect <= 1'h0;
      apb(1'h0, FPC_ADDR_CTRL, 32'h0);
      chk(rd, 32'h0000_5001);
      wr(FPC_ADDR_IRQ_CLR, 32'h7);
      apb(1'h0, FPC_ADDR_IRQ_STAT, 32'h0);
      chk({rd[30:0], irq}, 32'h0);
      // masked event still latches status but keeps the line low
      wr(FPC_ADDR_IRQ_EN, 32'h0);
      lv_detect <= 1'h1;
      apb(1'h0, FPC_ADDR_IRQ_STAT, 32'h0);
      lv_detect <= 1'h0;
      chk({rd[30:0], irq}, 32'h8);
      wr(FPC_ADDR_IRQ_CLR, 32'h7);
      $display("end of low voltage test");
   endtask

   task automatic t_ops();
      logic [3:0] ops[9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h2, 4'h6,
                             4'h7, 4'hF};
      logic [8:0] er_v = 9'h004;
      logic [8:0] ns_v = 9'h01E;
      logic [8:0] ef_v = 9'h184;
      for (int i = 0; i < 9; i++) begin
         run(ops[i], er_v[i], ns_v[i], ef_v[i]);
      end
      // protected target: nothing reaches the array
      wr(FPC_ADDR_PROT, 32'h0000_0200);
      run(4'h4, 1'h0, 1'h0, 1'h1);
      run(4'h5, 1'h0, 1'h0, 1'h1);
      run(4'h1, 1'h0, 1'h0, 1'h1);
      // a nop trigger now wipes the failure left by the runs above
      run(4'h0, 1'h0, 1'h0, 1'h0);
      $display("end of operation test");
   endtask

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // =====================================================
   // main sequence and watchdog
   initial begin
      {psel, penable, pwrite, lv_detect, err_req, rstn} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      slow = 1'h1;
      repeat (3) @(posedge clock);
      rstn <= 1'h1;
      t_reset();
      t_guard();
      t_lv();
      t_ops();
      print_verdict();
   end

   initial begin
      repeat (6000) @(posedge clock);
      errors++;
      print_verdict();
   end
endmodule
